// [clock_source_select_startup_bench.sv]
/* Testbench for the clock controller: APB tasks and register sequences.
   Assumes the oscillator model runs every source the controller enables. */
`timescale 1ns/1ns
`default_nettype none
module clock_source_select_startup_bench import csc_pkg::*; ;
	localparam int HB = 20;
	localparam int HS = 4;
	localparam logic [5:0] CODES [6] = '{6'h10, 6'h03, 6'h05, 6'h08, 6'h1F, 6'h22};
	localparam logic [4:0] MUXE [6] = '{5'h01, 5'h04, 5'h08, 5'h10, 5'h10, 5'h02};
	localparam logic [3:0] PINS [6] = '{4'hD, 4'hC, 4'hA, 4'hA, 4'hA, 4'hC};
	localparam int MINT [6] = '{6, 6, 6, 258, 20, 6};
	logic        mclk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        psel_in = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic [3:0]  fsel = 4'h2;
	logic [1:0]  fsut = 2'h2;
	logic        fdiv = 1'b0;
	logic        frst = 1'b1;
	logic        wake_in = 1'b0;
	logic [1:0]  slp = CSC_SLP_ACTIVE;
	logic        pready, perr, core, prog, peri, asy, conv, wdt, div8;
	logic [31:0] prdata, q, prev;
	logic [4:0]  sen, mux, tog;
	logic [1:0]  pin4, pin5;
	logic [7:0]  trim;
	logic        err;
	int          failures = 0;
	int          samples_checked = 0;
	time         t0;
	csc_clock_ctrl #(.LONG_TIMEOUT_CYC(16), .XTAL_LONG_CK(20)) dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .pready_out(pready), .pslverr_out(perr), .prdata_out(prdata),
		.fuse_source_select_in(fsel), .fuse_startup_time_in(fsut), .divide_by_eight_fuse_in(fdiv),
		.reset_pin_disable_fuse_in(frst), .factory_trim_in(8'h5A), .osc_toggle_in(tog), .wake_in(wake_in),
		.sleep_mode_in(slp), .source_enable_out(sen), .source_mux_out(mux), .port_b_pin_four_role_out(pin4),
		.port_b_pin_five_role_out(pin5), .core_clock_en_out(core), .program_memory_clock_en_out(prog),
		.peripheral_clock_en_out(peri), .async_timer_clock_en_out(asy), .converter_clock_en_out(conv),
		.watchdog_clock_en_out(wdt), .clock_div8_out(div8), .rc_trim_out(trim));
	csc_osc_model #(.HALF_BASE(HB), .HALF_STEP(HS)) u_osc (.enable_in(sen), .toggle_out(tog));
	always #4 mclk_in = ~mclk_in;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = perr;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (n >= 50) begin
			failures++;
			end_sim();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	task automatic poll();
		int n;
		n = 0;
		do begin
			apb(1'b0, CSC_OFS_STATUS, 32'h0);
			n++;
		end while ((q & 32'h180) !== 32'h100 && n < 3000);
		if (n >= 3000) begin
			failures++;
			end_sim();
		end
	endtask : poll
	task automatic do_reset();
		sys_rst_in <= 1'b1;
		repeat (5) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		t0 = $time;
	endtask : do_reset
	task automatic end_sim();
		$display("Checks %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial begin
		do_reset();
		rd(CSC_OFS_SELECT, 32'h22);
		rd(CSC_OFS_FUSE, 32'hA2);
		rd(CSC_OFS_TRIM, 32'h5A);
		rd(CSC_OFS_GATE, 32'h10);
		chk({28'h0, div8, 1'b0, pin4}, 32'h8);
		poll();
		chk({31'h0, core}, 32'h1);
		chk({31'h0, $time - t0 >= (16 - 1) * 2 * (HB + 2 * HS) + (14 - 1) * 2 * (HB + HS)}, 32'h1);
		apb(1'b1, CSC_OFS_TRIM, 32'hC3);
		rd(CSC_OFS_TRIM, 32'hC3);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, CSC_OFS_FUSE, 32'h0);
		rd(CSC_OFS_FUSE, 32'hA2);
		apb(1'b1, CSC_OFS_GATE, 32'h1C);
		@(negedge mclk_in);
		chk({29'h0, asy, pin5}, {29'h0, 1'b1, CSC_PIN_CLKOUT});
		foreach (CODES[i]) begin
			apb(1'b0, CSC_OFS_SELECT, 32'h0);
			prev = q;
			apb(1'b1, CSC_OFS_SELECT, {26'h0, CODES[i]});
			t0 = $time;
			rd(CSC_OFS_SELECT, prev);
			poll();
			chk({31'h0, $time - t0 >= (MINT[i] - 1) * 2 * (HB + HS * $clog2(MUXE[i]))}, 32'h1);
			rd(CSC_OFS_SELECT, {26'h0, CODES[i]});
			chk({27'h0, mux}, {27'h0, MUXE[i]});
			chk({28'h0, pin5, pin4}, {28'h0, PINS[i]});
		end
		slp <= CSC_SLP_DOWN;
		repeat (4) @(posedge mclk_in);
		chk({29'h0, core, wdt, asy}, 32'h3);
		wake_in <= 1'b1;
		slp <= CSC_SLP_ACTIVE;
		poll();
		wake_in <= 1'b0;
		chk({31'h0, core}, 32'h1);
		slp <= CSC_SLP_ADC;
		repeat (3) @(posedge mclk_in);
		chk({29'h0, core, peri, conv}, 32'h1);
		slp <= CSC_SLP_IDLE;
		repeat (3) @(posedge mclk_in);
		chk({29'h0, core, prog, peri}, 32'h1);
		slp <= CSC_SLP_ACTIVE;
		fsel <= 4'h8;
		frst <= 1'b0;
		fdiv <= 1'b1;
		do_reset();
		rd(CSC_OFS_SELECT, 32'h28);
		rd(CSC_OFS_FUSE, 32'h68);
		chk({27'h0, div8, pin5, pin4}, 32'hA);
		poll();
		chk({31'h0, $time - t0 >= 512 * 2 * (HB + 2 * HS)}, 32'h1);
		end_sim();
	end
endmodule : clock_source_select_startup_bench
`default_nettype wire

// [csc_clock_ctrl.sv]
/*
 * Clock source select and start-up sequencer with an APB register slave.
 * Assumes oscillator activity arrives as asynchronous level toggles slower than half of mclk_in,
 * and that a downstream glitch-free mux and gates act on the select and enable outputs.
 */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module csc_clock_ctrl
	import csc_pkg::*;
#(
	parameter int LONG_TIMEOUT_CYC = CSC_TO_LONG,
	parameter int XTAL_LONG_CK     = CSC_CK_XTAL_16K
) (
	input  wire logic              mclk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [7:0]        paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output logic                   pready_out,
	output logic                   pslverr_out,
	output logic      [31:0]       prdata_out,
	input  wire logic [3:0]        fuse_source_select_in,
	input  wire logic [1:0]        fuse_startup_time_in,
	input  wire logic              divide_by_eight_fuse_in,
	input  wire logic              reset_pin_disable_fuse_in,
	input  wire logic [7:0]        factory_trim_in,
	input  wire logic [4:0]        osc_toggle_in,
	input  wire logic              wake_in,
	input  wire logic [1:0]        sleep_mode_in,
	output logic      [4:0]        source_enable_out,
	output logic      [4:0]        source_mux_out,
	output logic      [1:0]        port_b_pin_four_role_out,
	output logic      [1:0]        port_b_pin_five_role_out,
	output logic                   core_clock_en_out,
	output logic                   program_memory_clock_en_out,
	output logic                   peripheral_clock_en_out,
	output logic                   async_timer_clock_en_out,
	output logic                   converter_clock_en_out,
	output logic                   watchdog_clock_en_out,
	output logic                   clock_div8_out,
	output logic      [7:0]        rc_trim_out
);

	// ------------------------------------------------------------
	// Types and state
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_TIMEOUT = 6'b000001,
		ST_RST_CK  = 6'b000010,
		ST_RUN     = 6'b000100,
		ST_SLEEP   = 6'b001000,
		ST_WAKE    = 6'b010000,
		ST_SWITCH  = 6'b100000
	} csc_state_t;

	csc_state_t  state_reg;
	csc_state_t  state_next;
	logic [3:0]  sel_reg;
	logic [1:0]  sut_reg;
	logic [3:0]  pend_sel_reg;
	logic [1:0]  pend_sut_reg;
	logic [7:0]  trim_reg;
	logic [4:0]  gate_reg;
	logic [14:0] count_reg;
	logic [14:0] count_next;
	logic [31:0] rdata_reg;
	logic [4:0]  mux_reg;
	logic [4:0]  sync1_reg;
	logic [4:0]  sync2_reg;
	logic [4:0]  sync3_reg;
	logic        wake1_reg;
	logic        wake2_reg;

	// ------------------------------------------------------------
	// Oscillator activity synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			sync3_reg <= 5'h00;
			wake1_reg <= 1'b0;
			wake2_reg <= 1'b0;
		end else begin
			sync1_reg <= osc_toggle_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			wake1_reg <= wake_in;
			wake2_reg <= wake1_reg;
		end
	end

	wire logic [4:0] tick = sync2_reg & ~sync3_reg;

	// ------------------------------------------------------------
	// Source decode and start-up lengths
	// ------------------------------------------------------------
	wire csc_src_t act_src   = csc_decode(sel_reg);
	wire csc_src_t pend_src  = csc_decode(pend_sel_reg);
	wire csc_wk_t  act_wk    = csc_wake(sel_reg, sut_reg);
	wire csc_wk_t  pend_wk   = csc_wake(pend_sel_reg, pend_sut_reg);
	wire csc_to_t  act_to    = csc_timeout(sel_reg, sut_reg, ~reset_pin_disable_fuse_in);    // RULE_14
	wire logic     act_tick  = tick[act_src];
	wire logic     pend_tick = tick[pend_src];
	wire logic     wdt_tick  = tick[CSC_SRC_WDT];                                           // RULE_13

	function automatic logic [14:0] wk_len(input csc_wk_t w);
		logic [14:0] n;
		unique case (w)
			CSC_WK_258: n = CSC_CK_XTAL_258;
			CSC_WK_1K:  n = CSC_CK_XTAL_1K;
			CSC_WK_16K: n = 15'(XTAL_LONG_CK);
			default:    n = CSC_CK_WAKE_RC;
		endcase
		return n;
	endfunction : wk_len

	wire logic [14:0] act_wk_len  = wk_len(act_wk);                                         // RULE_06
	wire logic [14:0] pend_wk_len = wk_len(pend_wk);                                        // RULE_21
	wire logic [14:0] to_len      = (act_to == CSC_TO_L) ? 15'(LONG_TIMEOUT_CYC) : CSC_TO_SHORT; // RULE_07

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire logic setup     = psel_in & ~penable_in;
	wire logic access_wr = psel_in & penable_in & pwrite_in;
	wire logic hit_sel   = paddr_in == CSC_OFS_SELECT;
	wire logic hit_trim  = paddr_in == CSC_OFS_TRIM;
	wire logic hit_gate  = paddr_in == CSC_OFS_GATE;
	wire logic hit_stat  = paddr_in == CSC_OFS_STATUS;
	wire logic hit_fuse  = paddr_in == CSC_OFS_FUSE;
	wire logic mapped    = hit_sel | hit_trim | hit_gate | hit_stat | hit_fuse;
	wire logic wr_sel    = access_wr & hit_sel;
	wire logic wr_trim   = access_wr & hit_trim;
	wire logic wr_gate   = access_wr & hit_gate;
	wire logic new_src   = pwdata_in[3:0] != sel_reg;
	wire logic sw_req    = wr_sel & (state_reg == ST_RUN) & new_src;                         // RULE_05

	wire logic [31:0] stat_word = {21'h0, state_reg == ST_WAKE, state_reg == ST_TIMEOUT,
	                               state_reg == ST_RUN, state_reg == ST_SWITCH, act_src, pend_sel_reg};
	wire logic [31:0] fuse_word = {24'h0, reset_pin_disable_fuse_in, divide_by_eight_fuse_in,
	                               fuse_startup_time_in, fuse_source_select_in};             // RULE_14
	wire logic [31:0] rd_mux    = hit_sel  ? {26'h0, sut_reg, sel_reg} :
	                              hit_trim ? {24'h0, trim_reg} :
	                              hit_gate ? {27'h0, gate_reg} :
	                              hit_stat ? stat_word :
	                              hit_fuse ? fuse_word : 32'h0;

	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~mapped;
	assign prdata_out  = rdata_reg;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	wire logic go_sleep = sleep_mode_in == CSC_SLP_DOWN;

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		unique case (state_reg)
			ST_TIMEOUT: begin
				if (act_to == CSC_TO_NONE || count_reg == to_len) begin
					state_next = ST_RST_CK;                                              // RULE_07
					count_next = 15'h0000;
				end else if (wdt_tick)
					count_next = count_reg + 15'h0001;
			end
			ST_RST_CK: begin
				if (count_reg == CSC_CK_RESET) begin
					state_next = ST_RUN;                                                 // RULE_08
					count_next = 15'h0000;
				end else if (act_tick)
					count_next = count_reg + 15'h0001;
			end
			ST_RUN: begin
				count_next = 15'h0000;
				if (sw_req)
					state_next = ST_SWITCH;                                              // RULE_21
				else if (go_sleep)
					state_next = ST_SLEEP;
			end
			ST_SLEEP: begin
				count_next = 15'h0000;
				if (wake2_reg)
					state_next = ST_WAKE;                                                // RULE_15
			end
			ST_WAKE: begin
				if (count_reg == act_wk_len) begin
					state_next = ST_RUN;                                                 // RULE_06
					count_next = 15'h0000;
				end else if (act_tick)
					count_next = count_reg + 15'h0001;
			end
			ST_SWITCH: begin
				if (count_reg == pend_wk_len) begin
					state_next = ST_RUN;                                                 // RULE_21
					count_next = 15'h0000;
				end else if (pend_tick)
					count_next = count_reg + 15'h0001;                                   // RULE_06
			end
		endcase
	end

	wire logic sw_done = (state_reg == ST_SWITCH) & (state_next == ST_RUN);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			state_reg <= ST_TIMEOUT;
			count_reg <= 15'h0000;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// ------------------------------------------------------------
	// Select, trim and gate registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sel_reg      <= fuse_source_select_in;                                      // RULE_04
			sut_reg      <= fuse_startup_time_in;                                       // RULE_04
			pend_sel_reg <= fuse_source_select_in;
			pend_sut_reg <= fuse_startup_time_in;
		end else if (sw_req) begin
			pend_sel_reg <= pwdata_in[3:0];
			pend_sut_reg <= pwdata_in[5:4];
		end else if (sw_done) begin
			sel_reg      <= pend_sel_reg;                                               // RULE_21
			sut_reg      <= pend_sut_reg;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			trim_reg <= factory_trim_in;                                                // RULE_11
			gate_reg <= {~divide_by_eight_fuse_in, CSC_GATE_RESET[3:0]};                // RULE_10
		end else begin
			if (wr_trim)
				trim_reg <= pwdata_in[7:0];                                             // RULE_12
			if (wr_gate)
				gate_reg <= pwdata_in[4:0];                                             // RULE_19
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			rdata_reg <= 32'h0;
			mux_reg   <= 5'h00;
		end else begin
			if (setup & ~pwrite_in)
				rdata_reg <= rd_mux;
			mux_reg <= 5'(1) << act_src;                                                // RULE_21
		end
	end

	// ------------------------------------------------------------
	// Source enables, pin roles and clock gates
	// ------------------------------------------------------------
	wire logic running   = state_reg == ST_RUN || state_reg == ST_SWITCH;
	wire logic asleep    = state_reg == ST_SLEEP;
	wire logic async_on  = gate_reg[2];
	wire logic [4:0] act_oh  = 5'(1) << act_src;
	wire logic [4:0] pend_oh = (state_reg == ST_SWITCH) ? 5'(1) << pend_src : 5'h00;
	wire logic [4:0] main_en = asleep ? 5'h00 : (act_oh | pend_oh);
	wire logic [4:0] asy_en  = async_on ? 5'(1) << CSC_SRC_LFX : 5'h00;               // RULE_16
	wire logic xtal_pins     = act_src == CSC_SRC_XTAL || act_src == CSC_SRC_LFX;

	assign source_enable_out = main_en | asy_en | (5'(1) << CSC_SRC_WDT);               // RULE_13
	assign source_mux_out    = mux_reg;                                                 // RULE_01
	assign port_b_pin_four_role_out = xtal_pins ? CSC_PIN_OSC :                          // RULE_03
	                                  (act_src == CSC_SRC_EXT) ? CSC_PIN_CLKIN : CSC_PIN_GPIO;
	assign port_b_pin_five_role_out = xtal_pins ? CSC_PIN_OSC :                          // RULE_03
	                                  gate_reg[3] ? CSC_PIN_CLKOUT : CSC_PIN_GPIO;

	wire logic core_on = running & (sleep_mode_in == CSC_SLP_ACTIVE);                   // RULE_15
	assign core_clock_en_out           = core_on;
	assign program_memory_clock_en_out = core_on;                                       // RULE_18
	assign peripheral_clock_en_out     = running & ~gate_reg[0] &                        // RULE_19
	                                     (sleep_mode_in == CSC_SLP_ACTIVE || sleep_mode_in == CSC_SLP_IDLE);
	assign converter_clock_en_out      = running & ~gate_reg[1] & ~go_sleep;            // RULE_17
	assign async_timer_clock_en_out    = async_on;                                      // RULE_16
	assign watchdog_clock_en_out       = 1'b1;                                          // RULE_13
	assign clock_div8_out              = gate_reg[4];                                   // RULE_10
	assign rc_trim_out                 = trim_reg;                                      // RULE_11

endmodule : csc_clock_ctrl
`default_nettype wire

// [csc_ctrl_checker.sv]
/* Port checker for the clock source select and start-up controller.
   Bound to csc_clock_ctrl; sees only its ports, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module csc_ctrl_checker
	import csc_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        sys_rst_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [7:0]  factory_trim_in,
	input wire logic        divide_by_eight_fuse_in,
	input wire logic [4:0]  source_enable_out,
	input wire logic [4:0]  source_mux_out,
	input wire logic [1:0]  port_b_pin_four_role_out,
	input wire logic        core_clock_en_out,
	input wire logic        program_memory_clock_en_out,
	input wire logic        async_timer_clock_en_out,
	input wire logic        watchdog_clock_en_out,
	input wire logic        clock_div8_out,
	input wire logic [7:0]  rc_trim_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	wire logic       trim_wr = psel_in && penable_in && pwrite_in && paddr_in == CSC_OFS_TRIM;
	wire logic [7:0] wtrim   = pwdata_in[7:0];
	a_core_settle: assert property ($fell(sys_rst_in) |-> !core_clock_en_out [*8])
		else $error("core clock on too soon after reset");
	a_div8_reset: assert property ($fell(sys_rst_in) |-> clock_div8_out == !divide_by_eight_fuse_in)
		else $error("divider not taken from fuse");
	a_trim_reset: assert property ($fell(sys_rst_in) |-> rc_trim_out == factory_trim_in)
		else $error("trim not loaded at reset");
	a_trim_write: assert property (trim_wr |=> rc_trim_out == $past(wtrim))
		else $error("trim write lost");
	a_prog_core: assert property (core_clock_en_out |-> program_memory_clock_en_out)
		else $error("program clock off while core runs");
	a_wdt_runs: assert property (watchdog_clock_en_out && source_enable_out[2])
		else $error("watchdog oscillator stopped");
	a_pin_xtal: assert property (port_b_pin_four_role_out == CSC_PIN_OSC |=> |source_mux_out[4:3])
		else $error("oscillator pins without crystal source");
	a_pin_clkin: assert property (port_b_pin_four_role_out == CSC_PIN_CLKIN |=> source_mux_out[0])
		else $error("clock input pin without external source");
	a_async_src: assert property (async_timer_clock_en_out |-> source_enable_out[3])
		else $error("async timer clock without its oscillator");
	c_trim_wr: cover property (trim_wr);
	c_xtal_sel: cover property ($rose(source_mux_out[4]));
	c_core_off: cover property ($fell(core_clock_en_out));
endmodule : csc_ctrl_checker
bind csc_clock_ctrl csc_ctrl_checker u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.factory_trim_in(factory_trim_in), .divide_by_eight_fuse_in(divide_by_eight_fuse_in),
	.source_enable_out(source_enable_out), .source_mux_out(source_mux_out),
	.port_b_pin_four_role_out(port_b_pin_four_role_out), .core_clock_en_out(core_clock_en_out),
	.program_memory_clock_en_out(program_memory_clock_en_out), .clock_div8_out(clock_div8_out),
	.async_timer_clock_en_out(async_timer_clock_en_out), .rc_trim_out(rc_trim_out),
	.watchdog_clock_en_out(watchdog_clock_en_out));
`default_nettype wire

// [csc_osc_model.sv]
/* Oscillator activity model: each enabled source toggles its line.
   Assumes enables come from the controller; a stopped source holds its line. */
`timescale 1ns/1ns
`default_nettype none
module csc_osc_model #(
	parameter int HALF_BASE = 20,
	parameter int HALF_STEP = 4
) (
	input  wire logic [4:0] enable_in,
	output wire logic [4:0] toggle_out
);
	for (genvar i = 0; i < 5; i++) begin : g_osc
		logic t = 1'b0;
		assign toggle_out[i] = t;
		// Phase offset keeps toggles off both controller clock edges
		initial begin
			#2;
			forever begin
				#(HALF_BASE + HALF_STEP * i);
				if (enable_in[i] === 1'b1) begin
					t = ~t;
				end
			end
		end
	end
endmodule : csc_osc_model
`default_nettype wire

// [csc_pkg.sv]
/*
 * Constants, types and decode helpers for the clock source select and start-up block.
 * Assumes one controller clock and oscillator activity seen as slow level toggles.
 */
//
// Notes on behaviour
// RULE_01 - Code 0000 external clock, 0010 internal 8 MHz RC, 0011 watchdog oscillator.
// RULE_02 - 01xx low-frequency crystal; 100x..111x crystal ranges rising up to 16 MHz.
// RULE_03 - Pin roles follow source: clock input, oscillator terminals, or general I/O.
// RULE_04 - Reset copies fuse source and start-up fields into the runtime select register.
// RULE_05 - Software may switch to any other source while running.
// RULE_06 - Wake or newly enabled source counts its own start-up cycles before running.
// RULE_07 - Reset adds watchdog-timed settling: 512 short, 8192 long cycles.
// RULE_08 - RC source: 6 CK wake; reset 14 CK plus none, short, long; 11 reserved. Here 11 selects the long time-out.
// RULE_09 - Setting without time-out only allowed while reset pin disable fuse is unset.
// RULE_10 - Delivered fuses: source 0010, start-up 10, divide by eight programmed.
// RULE_11 - Reset loads factory trim into the RC trim register.
// RULE_12 - Software may rewrite the RC trim register.
// RULE_13 - Watchdog oscillator keeps running for watchdog and reset time-out.
// RULE_14 - Fuse bit reads 1 unprogrammed, 0 programmed.
// RULE_15 - Core clock halt stops core; wake events still seen with peripheral clock off.
// RULE_16 - Async timer clock from external clock or low-frequency crystal, runs in sleep; here only the low-frequency crystal source is enabled for it.
// RULE_17 - Converter clock stays on while core and peripheral clocks halt.
// RULE_18 - Program memory clock runs whenever core clock runs.
// RULE_19 - Unused module clocks gated by sleep modes or software.
// RULE_20 - Crystal: low select bit plus start-up field pick 258, 1024, 16384 CK.
// RULE_21 - Switch keeps old source until new start-up count ends, then changes.
package csc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] CSC_OFS_SELECT = 8'h00;
	localparam logic [7:0] CSC_OFS_TRIM   = 8'h04;
	localparam logic [7:0] CSC_OFS_GATE   = 8'h08;
	localparam logic [7:0] CSC_OFS_STATUS = 8'h0C;
	localparam logic [7:0] CSC_OFS_FUSE   = 8'h10;
	localparam logic [4:0] CSC_GATE_RESET = 5'h00;

	// ------------------------------------------------------------
	// Source codes and indices
	// ------------------------------------------------------------
	localparam logic [3:0] CSC_SEL_EXT = 4'h0;
	localparam logic [3:0] CSC_SEL_RC  = 4'h2;
	localparam logic [3:0] CSC_SEL_WDT = 4'h3;
	localparam int         CSC_NSRC    = 5;
	typedef enum logic [2:0] {
		CSC_SRC_EXT  = 3'h0,
		CSC_SRC_RC   = 3'h1,
		CSC_SRC_WDT  = 3'h2,
		CSC_SRC_LFX  = 3'h3,
		CSC_SRC_XTAL = 3'h4
	} csc_src_t;

	// ------------------------------------------------------------
	// Start-up counts in oscillator cycles
	// ------------------------------------------------------------
	localparam logic [14:0] CSC_CK_WAKE_RC  = 15'h0006;
	localparam logic [14:0] CSC_CK_RESET    = 15'h000E;
	localparam logic [14:0] CSC_CK_XTAL_258 = 15'h0102;
	localparam logic [14:0] CSC_CK_XTAL_1K  = 15'h0400;
	localparam int          CSC_CK_XTAL_16K = 16384;
	localparam logic [14:0] CSC_TO_SHORT    = 15'h0200;
	localparam int          CSC_TO_LONG     = 8192;
	typedef enum logic [1:0] {
		CSC_TO_NONE = 2'h0,
		CSC_TO_S    = 2'h1,
		CSC_TO_L    = 2'h2
	} csc_to_t;
	typedef enum logic [1:0] {
		CSC_WK_6    = 2'h0,
		CSC_WK_258  = 2'h1,
		CSC_WK_1K   = 2'h2,
		CSC_WK_16K  = 2'h3
	} csc_wk_t;

	// ------------------------------------------------------------
	// Pin roles
	// ------------------------------------------------------------
	localparam logic [1:0] CSC_PIN_GPIO   = 2'h0;
	localparam logic [1:0] CSC_PIN_CLKIN  = 2'h1;
	localparam logic [1:0] CSC_PIN_OSC    = 2'h2;
	localparam logic [1:0] CSC_PIN_CLKOUT = 2'h3;

	// Sleep mode codes from the core
	localparam logic [1:0] CSC_SLP_ACTIVE = 2'h0;
	localparam logic [1:0] CSC_SLP_IDLE   = 2'h1;
	localparam logic [1:0] CSC_SLP_ADC    = 2'h2;
	localparam logic [1:0] CSC_SLP_DOWN   = 2'h3;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic csc_src_t csc_decode(input logic [3:0] sel);
		csc_src_t s;
		s = CSC_SRC_RC;
		if (sel[3])
			s = CSC_SRC_XTAL;                  // RULE_02
		else if (sel[2])
			s = CSC_SRC_LFX;                   // RULE_02
		else if (sel == CSC_SEL_EXT)
			s = CSC_SRC_EXT;                   // RULE_01
		else if (sel == CSC_SEL_WDT)
			s = CSC_SRC_WDT;                   // RULE_01
		return s;
	endfunction : csc_decode

	function automatic csc_wk_t csc_wake(input logic [3:0] sel, input logic [1:0] fuse_startup_time);
		csc_wk_t w;
		w = CSC_WK_6;
		if (sel[3]) begin
			if ({sel[0], fuse_startup_time} <= 3'h1)
				w = CSC_WK_258;                // RULE_20
			else if ({sel[0], fuse_startup_time} <= 3'h4)
				w = CSC_WK_1K;                 // RULE_20
			else
				w = CSC_WK_16K;                // RULE_20
		end
		return w;
	endfunction : csc_wake

	function automatic csc_to_t csc_timeout(input logic [3:0] sel, input logic [1:0] fuse_startup_time,
	                                         input logic rst_pin_off);
		csc_to_t t;
		t = CSC_TO_L;
		if (sel[3]) begin
			unique case ({sel[0], fuse_startup_time})
				3'h0, 3'h3, 3'h6: t = CSC_TO_S;
				3'h2, 3'h5:       t = rst_pin_off ? CSC_TO_S : CSC_TO_NONE;   // RULE_09
				default:          t = CSC_TO_L;
			endcase
		end else begin
			unique case (fuse_startup_time)
				2'h0:    t = rst_pin_off ? CSC_TO_S : CSC_TO_NONE;         // RULE_09
				2'h1:    t = CSC_TO_S;                                     // RULE_08
				default: t = CSC_TO_L;                                     // RULE_08
			endcase
		end
		return t;
	endfunction : csc_timeout

endpackage : csc_pkg
